// File: nas_alu.sv
// Nibble accumulator datapath with skip logic
// How it works
// - In a run of load-immediate-to-accumulator, only the first executes; the rest skip.
// - Table fetch puts ROM bits 7..4 into B and 3..0 into accumulator.
// - Table address is table_addr_high bits 2..0 above accumulator bits 3..0.
// - Table fetch pushes return address for one stack level, then pops it.
// - Add memory sums nibble into accumulator, carry flag unchanged.
// - Add memory with carry stores sum in accumulator and carry out in carry.
// - Add immediate keeps carry; skips next unless overflow occurs.
// - AND combines accumulator with memory nibble into accumulator.
// - OR combines accumulator with memory nibble into accumulator.
// - Set carry forces carry flag to one.
// - Clear carry forces carry flag to zero.
// - Skip if carry zero skips next when carry is zero, flag untouched.
// - Complement inverts all four accumulator bits.
// - Rotate shifts carry and accumulator right; carry to bit 3, bit 0 to carry.
// - Bit set writes one into memory bit j from low opcode bits.
// - Bit clear writes zero into memory bit j, other bits kept.
// - Bit test skips next when selected memory bit is zero.
// - Compare with memory skips next when accumulator equals nibble.
// - Compare with immediate is two words, two cycles; skips on equality.
module nas_alu (
  input  wire logic       CLK_I,
  input  wire logic       RST_B_I,
  input  wire logic       INSTR_VALID_I,
  input  wire logic [9:0] INSTR_I,
  input  wire logic [3:0] MEM_RDATA_I,
  input  wire logic [2:0] TABLE_ADDR_HIGH_I,
  input  wire logic [7:0] ROM_RDATA_I,
  output logic            BUSY_O,
  output logic      [3:0] ACC_O,
  output logic      [3:0] REGB_O,
  output logic            CARRY_FLAG_O,
  output logic            SKIP_NEXT_O,
  output logic            MEM_WE_O,
  output logic      [3:0] MEM_WDATA_O,
  output logic            ROM_RE_O,
  output logic      [6:0] ROM_ADDR_O,
  output logic            STACK_PUSH_O,
  output logic            STACK_POP_O
);

  typedef enum logic [1:0] {ST_IDLE, ST_TABLE, ST_CMP_IMM} nas_state_t;

  // ==========================================
  // Decode
  logic       is_lia;
  logic       is_addi;
  logic       is_tbl;
  logic       is_bset;
  logic       is_bclr;
  logic       is_bskip;
  logic [1:0] bit_sel;
  logic [3:0] imm;
  logic [4:0] sum_add;
  logic [4:0] sum_adc;

  assign is_lia   = INSTR_I[9:4] == nas_pkg::GRP_LOAD_IMM_ACC;
  assign is_addi  = INSTR_I[9:4] == nas_pkg::GRP_ADD_IMM;
  assign is_tbl   = INSTR_I[9:5] == nas_pkg::GRP_TABLE_FETCH;
  assign is_bset  = INSTR_I[9:2] == nas_pkg::GRP_BIT_SET_MEM;
  assign is_bclr  = INSTR_I[9:2] == nas_pkg::GRP_BIT_CLEAR_MEM;
  assign is_bskip = INSTR_I[9:2] == nas_pkg::GRP_SKIP_BIT_ZERO;
  assign bit_sel  = INSTR_I[nas_pkg::BITSEL_LSB +: 2];
  assign imm      = INSTR_I[nas_pkg::IMM_LSB +: 4];
  assign sum_add  = {1'b0, ACC_O} + {1'b0, MEM_RDATA_I};
  assign sum_adc  = sum_add + {4'h0, CARRY_FLAG_O};

  // ==========================================
  // Sequencing state
  nas_state_t state_q;
  logic [1:0] cnt_q;
  logic       skip_q;
  logic       skip_cnt_q;
  logic       last_lia_q;
  logic       exec;
  logic       skip_now;

  assign exec = INSTR_VALID_I && state_q == ST_IDLE && !skip_q;

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      state_q <= ST_IDLE;
      cnt_q   <= 2'h0;
      BUSY_O  <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (exec && is_tbl) begin
            state_q <= ST_TABLE;
            cnt_q   <= nas_pkg::TABLE_FETCH_CYCLES - 2'h1;
            BUSY_O  <= 1'b1;
          end else if (exec && INSTR_I == nas_pkg::OP_SKIP_ACC_EQ_IMM) begin
            state_q <= ST_CMP_IMM;
            cnt_q   <= nas_pkg::CMP_IMM_CYCLES - 2'h1;
            BUSY_O  <= 1'b1;
          end
        end
        ST_TABLE, ST_CMP_IMM: begin
          if (INSTR_VALID_I) begin
            cnt_q <= cnt_q - 2'h1;
            if (cnt_q == 2'h1) begin
              state_q <= ST_IDLE;
              BUSY_O  <= 1'b0;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
          BUSY_O  <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================
  // Load run tracking
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      last_lia_q <= 1'b0;
    end else if (INSTR_VALID_I && state_q == ST_IDLE) begin
      // remember a load in the run
      last_lia_q <= is_lia;
    end
  end

  // ==========================================
  // Skip flag: one skipped word, two if it is a compare-immediate
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      skip_q     <= 1'b0;
      skip_cnt_q <= 1'b0;
    end else if (INSTR_VALID_I && state_q == ST_IDLE) begin
      if (skip_q) begin
        if (INSTR_I == nas_pkg::OP_SKIP_ACC_EQ_IMM && !skip_cnt_q) begin
          skip_cnt_q <= 1'b1;
        end else begin
          skip_q     <= 1'b0;
          skip_cnt_q <= 1'b0;
        end
        if (is_lia) begin
          skip_q     <= 1'b0;
          skip_cnt_q <= 1'b0;
        end
      end else begin
        skip_q <= skip_now;
      end
    end else if (INSTR_VALID_I && state_q == ST_CMP_IMM && cnt_q == 2'h1) begin
      skip_q <= ACC_O == INSTR_I[3:0];
    end
  end

  // ==========================================
  // Skip condition of current word
  // Pending skip shown straight from its flop
  assign SKIP_NEXT_O = skip_q;

  always_comb begin
    skip_now = 1'b0;
    if (exec) begin
      if (is_addi) begin
        skip_now = !(({1'b0, ACC_O} + {1'b0, imm}) > 5'h0F);
      end
      if (INSTR_I == nas_pkg::OP_SKIP_CARRY_ZERO) begin
        skip_now = !CARRY_FLAG_O;
      end
      if (is_bskip) begin
        skip_now = !MEM_RDATA_I[bit_sel];
      end
      if (INSTR_I == nas_pkg::OP_SKIP_ACC_EQ_MEM) begin
        skip_now = ACC_O == MEM_RDATA_I;
      end
    end
  end

  // ==========================================
  // Accumulator and register B
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      ACC_O  <= nas_pkg::ACC_RESET;
      REGB_O <= nas_pkg::REGB_RESET;
    end else if (exec) begin
      if (is_lia && !last_lia_q) begin
        ACC_O <= imm;
      end
      if (INSTR_I == nas_pkg::OP_ADD_MEMORY) begin
        ACC_O <= sum_add[3:0];
      end
      if (INSTR_I == nas_pkg::OP_ADD_MEM_CARRY) begin
        ACC_O <= sum_adc[3:0];
      end
      if (is_addi) begin
        ACC_O <= ACC_O + imm;
      end
      if (INSTR_I == nas_pkg::OP_AND_MEM) begin
        ACC_O <= ACC_O & MEM_RDATA_I;
      end
      if (INSTR_I == nas_pkg::OP_OR_MEM) begin
        ACC_O <= ACC_O | MEM_RDATA_I;
      end
      if (INSTR_I == nas_pkg::OP_COMPLEMENT_ACC) begin
        ACC_O <= ~ACC_O;
      end
      if (INSTR_I == nas_pkg::OP_ROTATE_RIGHT) begin
        ACC_O <= {CARRY_FLAG_O, ACC_O[3:1]};
      end
    end else if (state_q == ST_TABLE && INSTR_VALID_I && cnt_q == 2'h1) begin
      REGB_O <= ROM_RDATA_I[7:nas_pkg::TBL_HI_LSB];
      ACC_O  <= ROM_RDATA_I[nas_pkg::TBL_HI_LSB-1:0];
    end
  end

  // ==========================================
  // Carry flag
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      CARRY_FLAG_O <= nas_pkg::CARRY_RESET;
    end else if (exec) begin
      if (INSTR_I == nas_pkg::OP_ADD_MEM_CARRY) begin
        CARRY_FLAG_O <= sum_adc[4];
      end
      if (INSTR_I == nas_pkg::OP_SET_CARRY) begin
        CARRY_FLAG_O <= 1'b1;
      end
      if (INSTR_I == nas_pkg::OP_CLEAR_CARRY) begin
        CARRY_FLAG_O <= 1'b0;
      end
      if (INSTR_I == nas_pkg::OP_ROTATE_RIGHT) begin
        CARRY_FLAG_O <= ACC_O[0];
      end
    end
  end

  // ==========================================
  // Per-bit write data for bit set and clear
  logic [3:0] bit_wdata;
  for (genvar k = 0; k < 4; k++) begin : g_bit_wdata
    assign bit_wdata[k] = (bit_sel == 2'(k)) ? is_bset : MEM_RDATA_I[k];
  end

  // ==========================================
  // Memory write-back
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      MEM_WE_O    <= 1'b0;
      MEM_WDATA_O <= 4'h0;
    end else begin
      MEM_WE_O <= exec && (is_bset || is_bclr);
      if (is_bset) begin
        MEM_WDATA_O <= bit_wdata;
      end
      if (is_bclr) begin
        MEM_WDATA_O <= bit_wdata;
      end
    end
  end

  // ==========================================
  // Table fetch ROM access and stack use
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      ROM_RE_O     <= 1'b0;
      ROM_ADDR_O   <= 7'h00;
      STACK_PUSH_O <= 1'b0;
      STACK_POP_O  <= 1'b0;
    end else begin
      STACK_PUSH_O <= exec && is_tbl;
      STACK_POP_O  <= state_q == ST_TABLE && INSTR_VALID_I && cnt_q == 2'h1;
      ROM_RE_O     <= exec && is_tbl;
      if (exec && is_tbl) begin
        ROM_ADDR_O <= {TABLE_ADDR_HIGH_I, ACC_O};
      end
    end
  end

endmodule

// File: nas_pkg.sv
// Opcodes, field positions, reset values and cycle counts for the nibble ALU
package nas_pkg;
  // ==========================================
  // Opcode values (10-bit instruction words)
  localparam logic [9:0] OP_ADD_MEMORY       = 10'h00A;
  localparam logic [9:0] OP_ADD_MEM_CARRY    = 10'h00B;
  localparam logic [9:0] OP_AND_MEM          = 10'h018;
  localparam logic [9:0] OP_OR_MEM           = 10'h019;
  localparam logic [9:0] OP_SET_CARRY        = 10'h007;
  localparam logic [9:0] OP_CLEAR_CARRY      = 10'h006;
  localparam logic [9:0] OP_SKIP_CARRY_ZERO  = 10'h02F;
  localparam logic [9:0] OP_COMPLEMENT_ACC   = 10'h01C;
  localparam logic [9:0] OP_ROTATE_RIGHT     = 10'h01D;
  localparam logic [9:0] OP_SKIP_ACC_EQ_MEM  = 10'h026;
  localparam logic [9:0] OP_SKIP_ACC_EQ_IMM  = 10'h025;
  // Opcode groups: upper bits compared, low field is operand
  localparam logic [5:0] GRP_LOAD_IMM_ACC    = 6'h07;
  localparam logic [5:0] GRP_ADD_IMM         = 6'h06;
  localparam logic [4:0] GRP_TABLE_FETCH     = 5'h04;
  localparam logic [7:0] GRP_BIT_SET_MEM     = 8'h17;
  localparam logic [7:0] GRP_BIT_CLEAR_MEM   = 8'h13;
  localparam logic [7:0] GRP_SKIP_BIT_ZERO   = 8'h08;
  // Second word of the compare-with-immediate
  localparam logic [5:0] GRP_CMP_IMM_SECOND  = 6'h07;
  // ==========================================
  // Field positions
  localparam int IMM_LSB   = 0;
  localparam int BITSEL_LSB = 0;
  localparam int TBL_HI_LSB = 4;
  // ==========================================
  // Cycle counts
  localparam logic [1:0] TABLE_FETCH_CYCLES = 2'h3;
  localparam logic [1:0] CMP_IMM_CYCLES     = 2'h2;
  // ==========================================
  // Reset values
  localparam logic [3:0] ACC_RESET   = 4'h0;
  localparam logic [3:0] REGB_RESET  = 4'h0;
  localparam logic       CARRY_RESET = 1'b0;
endpackage

// File: nas_mem_model.sv
// Data memory nibble and table ROM facing the ALU
module nas_mem_model (
  input  wire logic       clk_i,
  input  wire logic       mem_we_i,
  input  wire logic [3:0] mem_wdata_i,
  input  wire logic [6:0] rom_addr_i,
  output logic      [3:0] mem_rdata_o,
  output logic      [7:0] rom_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Storage
  logic [3:0] mem_q = 4'h0;
  always @(posedge clk_i) if (mem_we_i) mem_q <= mem_wdata_i;
  assign mem_rdata_o = mem_q;
  assign rom_rdata_o = {~rom_addr_i[3:0] ^ {1'b0, rom_addr_i[6:4]}, rom_addr_i[3:0] ^ 4'h9};
endmodule

// File: nas_alu_checker.sv
// Port assertions for the nibble ALU
module nas_alu_checker (
  input wire logic       CLK_I,
  input wire logic       RST_B_I,
  input wire logic       INSTR_VALID_I,
  input wire logic [9:0] INSTR_I,
  input wire logic [3:0] MEM_RDATA_I,
  input wire logic [2:0] TABLE_ADDR_HIGH_I,
  input wire logic       BUSY_O,
  input wire logic [3:0] ACC_O,
  input wire logic       CARRY_FLAG_O,
  input wire logic       SKIP_NEXT_O,
  input wire logic       MEM_WE_O,
  input wire logic [3:0] MEM_WDATA_O,
  input wire logic       ROM_RE_O,
  input wire logic [6:0] ROM_ADDR_O,
  input wire logic       STACK_PUSH_O,
  input wire logic       STACK_POP_O
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Executed word tracking
  logic exe;
  assign exe = INSTR_VALID_I && !SKIP_NEXT_O && !BUSY_O;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);
  // ==========
  // Assertions
  sequence tf_issue_s; exe && INSTR_I[9:5] == nas_pkg::GRP_TABLE_FETCH; endsequence
  sequence tf_stack_s; ROM_RE_O && STACK_PUSH_O && BUSY_O; endsequence
  sequence tf_walk_s; tf_issue_s ##1 INSTR_VALID_I ##1 INSTR_VALID_I; endsequence
  sequence ci_issue_s; exe && INSTR_I == nas_pkg::OP_SKIP_ACC_EQ_IMM ##1 INSTR_VALID_I; endsequence
  table_stack_a: assert property (tf_issue_s |=> tf_stack_s)
    else $error("table fetch stack pulses wrong");
  table_pop_a: assert property (tf_walk_s |=> STACK_POP_O && !BUSY_O)
    else $error("table fetch stack pop wrong");
  cmp_imm_skip_a: assert property (ci_issue_s |-> BUSY_O ##1
    (!BUSY_O && SKIP_NEXT_O == ($past(INSTR_I[3:0]) == $past(ACC_O))))
    else $error("compare immediate skip wrong");
  table_addr_a: assert property (tf_issue_s |=>
    ROM_ADDR_O == {$past(TABLE_ADDR_HIGH_I), $past(ACC_O)}) else $error("table address wrong");
  set_carry_a: assert property (exe && INSTR_I == nas_pkg::OP_SET_CARRY |=>
    CARRY_FLAG_O && $stable(ACC_O)) else $error("set carry wrong");
  clear_carry_a: assert property (exe && INSTR_I == nas_pkg::OP_CLEAR_CARRY |=>
    !CARRY_FLAG_O && $stable(ACC_O)) else $error("clear carry wrong");
  complement_acc_a: assert property (exe && INSTR_I == nas_pkg::OP_COMPLEMENT_ACC |=>
    ACC_O == ~$past(ACC_O)) else $error("complement wrong");
  rotate_chain_a: assert property (exe && INSTR_I == nas_pkg::OP_ROTATE_RIGHT |=>
    {ACC_O, CARRY_FLAG_O} == {$past(CARRY_FLAG_O), $past(ACC_O)}) else $error("rotate wrong");
  carry_skip_a: assert property (exe && INSTR_I == nas_pkg::OP_SKIP_CARRY_ZERO |=>
    SKIP_NEXT_O == !$past(CARRY_FLAG_O) && $stable(CARRY_FLAG_O)) else $error("carry skip wrong");
  bit_set_a: assert property (exe && INSTR_I[9:2] == nas_pkg::GRP_BIT_SET_MEM |=>
    MEM_WE_O && MEM_WDATA_O == ($past(MEM_RDATA_I) | (4'h1 << $past(INSTR_I[1:0]))))
    else $error("bit set write wrong");
  bit_clear_a: assert property (exe && INSTR_I[9:2] == nas_pkg::GRP_BIT_CLEAR_MEM |=>
    MEM_WE_O && MEM_WDATA_O == ($past(MEM_RDATA_I) & ~(4'h1 << $past(INSTR_I[1:0]))))
    else $error("bit clear write wrong");
endmodule

// File: tb_nibble_alu_skip_logic.sv
// Self-checking bench for the nibble ALU
module tb_nibble_alu_skip_logic;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Signals and model state
  logic        CLK_I = 1'b0;
  logic        RST_B_I = 1'b0;
  logic        INSTR_VALID_I = 1'b0;
  logic [9:0]  INSTR_I = 10'h000;
  logic [2:0]  TABLE_ADDR_HIGH_I = 3'h0;
  logic [3:0]  MEM_RDATA_I, ACC_O, REGB_O, MEM_WDATA_O, a = 4'h0, b = 4'h0, m = 4'h0;
  logic [7:0]  ROM_RDATA_I;
  logic [6:0]  ROM_ADDR_O, t;
  logic        BUSY_O, CARRY_FLAG_O, SKIP_NEXT_O, MEM_WE_O, ROM_RE_O, STACK_PUSH_O, STACK_POP_O;
  logic        c = 1'b0, pla = 1'b0, cmpi = 1'b0, tk = 1'b0;
  logic [31:0] s = 32'h172EA, r;
  logic [9:0]  q[$], e;
  logic [9:0]  seq1[8] = '{10'h07A, 10'h075, 10'h073, 10'h006, 10'h02F, 10'h025, 10'h07A, 10'h01C};
  int          skp = 0, error_cnt = 0, checked = 0, cyc = 0;
  always #12.5 CLK_I = ~CLK_I;
  nas_alu i_nas_alu (.*);
  nas_mem_model i_nas_mem_model (.clk_i(CLK_I), .mem_we_i(MEM_WE_O), .mem_wdata_i(MEM_WDATA_O),
    .rom_addr_i(ROM_ADDR_O), .mem_rdata_o(MEM_RDATA_I), .rom_rdata_o(ROM_RDATA_I));
  // ==========
  // Drivers and expected state
  function automatic logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  task automatic d(input logic [9:0] x);
    @(posedge CLK_I);
    #1;
    INSTR_VALID_I = 1'b1;
    INSTR_I = x;
    r = rnd();
    TABLE_ADDR_HIGH_I = r[2:0];
    q.push_back({a, b, c, skp > 0});
  endtask
  task automatic idle();
    @(posedge CLK_I);
    #1;
    INSTR_VALID_I = 1'b0;
  endtask
  task automatic w(input logic [9:0] x);
    logic [4:0] sum;
    if (skp > 0) begin
      skp = skp - 1 + int'(x == nas_pkg::OP_SKIP_ACC_EQ_IMM);
      pla = x[9:4] == nas_pkg::GRP_LOAD_IMM_ACC;
    end else if (cmpi) begin
      cmpi = 1'b0;
      skp = int'(a == x[3:0]);
    end else if (x[9:4] == nas_pkg::GRP_LOAD_IMM_ACC) begin
      if (!pla) a = x[3:0];
      pla = 1'b1;
    end else begin
      pla = 1'b0;
      sum = {1'b0, a} + {1'b0, x[3:0]};
      case (x)
        nas_pkg::OP_ADD_MEMORY: a = a + m;
        nas_pkg::OP_ADD_MEM_CARRY: {c, a} = a + m + c;
        nas_pkg::OP_AND_MEM: a = a & m;
        nas_pkg::OP_OR_MEM: a = a | m;
        nas_pkg::OP_SET_CARRY: c = 1'b1;
        nas_pkg::OP_CLEAR_CARRY: c = 1'b0;
        nas_pkg::OP_SKIP_CARRY_ZERO: skp = int'(!c);
        nas_pkg::OP_COMPLEMENT_ACC: a = ~a;
        nas_pkg::OP_ROTATE_RIGHT: {a, c} = {c, a};
        nas_pkg::OP_SKIP_ACC_EQ_MEM: skp = int'(a == m);
        nas_pkg::OP_SKIP_ACC_EQ_IMM: cmpi = 1'b1;
        default: begin
          if (x[9:4] == nas_pkg::GRP_ADD_IMM) {skp, a} = {31'h0, !sum[4], sum[3:0]};
          if (x[9:2] == nas_pkg::GRP_BIT_SET_MEM) m[x[1:0]] = 1'b1;
          if (x[9:2] == nas_pkg::GRP_BIT_CLEAR_MEM) m[x[1:0]] = 1'b0;
          if (x[9:2] == nas_pkg::GRP_SKIP_BIT_ZERO) skp = int'(!m[x[1:0]]);
        end
      endcase
    end
    d(x);
  endtask
  task automatic op(input int k, input logic [31:0] v);
    logic [9:0] ops[11] = '{10'h00A, 10'h00B, {6'h06, v[3:0]}, 10'h018, 10'h007, 10'h006,
                            10'h02F, 10'h01C, 10'h01D, {8'h08, v[5:4]}, 10'h026};
    if (k < 11) w(ops[k]);
    if (k == 11) begin
      w(nas_pkg::OP_SKIP_ACC_EQ_IMM);
      w({nas_pkg::GRP_CMP_IMM_SECOND, v[9] ? a : v[13:10]});
    end
    if (k == 12) begin
      pla = 1'b0;
      d({nas_pkg::GRP_TABLE_FETCH, v[15:11]});
      t = {TABLE_ADDR_HIGH_I, a};
      d(10'h000);
      {b, a} = {~t[3:0] ^ {1'b0, t[6:4]}, t[3:0] ^ 4'h9};
      d(10'h000);
    end
  endtask
  task automatic give_verdict();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========
  // Result monitor and time limit
  always @(posedge CLK_I) tk <= INSTR_VALID_I;
  always @(negedge CLK_I) begin
    if (tk) begin
      e = q.pop_front();
      checked++;
      if ({ACC_O, REGB_O, CARRY_FLAG_O, SKIP_NEXT_O} !== e) begin
        error_cnt++;
        $display("MISMATCH acc_b_carry_skip exp %h got %h", e,
                 {ACC_O, REGB_O, CARRY_FLAG_O, SKIP_NEXT_O});
      end
    end
  end
  always @(posedge CLK_I) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      give_verdict();
    end
  end
  // ==========
  // Main sequence
  initial begin
    repeat (12) @(posedge CLK_I);
    #1;
    RST_B_I = 1'b1;
    foreach (seq1[i]) w(seq1[i]);
    $display("load run and skipped compare test done");
    for (int i = 0; i < 130; i++) begin
      r = rnd();
      w({r[0] ? nas_pkg::GRP_BIT_SET_MEM : nas_pkg::GRP_BIT_CLEAR_MEM, r[2:1]});
      idle();
      w({nas_pkg::GRP_LOAD_IMM_ACC, r[4] ? m : r[8:5]});
      op(i % 13, r);
      w(nas_pkg::OP_OR_MEM);
    end
    idle();
    repeat (2) @(posedge CLK_I);
    $display("operation mix test done");
    give_verdict();
  end
endmodule
bind nas_alu nas_alu_checker i_nas_alu_checker (.*);
